// File: rtl/efc_defs.svh
`ifndef EFC_DEFS_SVH
`define EFC_DEFS_SVH
// position, speed, deviation, summary and sensor widths
`define EFC_POS_W        40
`define EFC_SPD_W        16
`define EFC_DEV_W        24
`define EFC_SUM_W        8
`define EFC_SENS_W       16
// reset values
`define EFC_POS_RST      40'h00_0000_0000
`define EFC_DEV_RST      24'h00_0000
// free-running package spacing: 11.52 us at 4 ns period
`define EFC_FREE_PKG_NS  11520
`define EFC_CLK_NS       4
`define EFC_FREE_PKG_CYC (`EFC_FREE_PKG_NS / `EFC_CLK_NS)
`endif

// File: rtl/efc_pkg.sv
package efc_pkg;
    // fast channel contents of one package
    typedef struct packed {
        logic [39:0] pos;
        logic [15:0] spd;
    } efc_fast_t;
    // safe channel contents of one package
    typedef struct packed {
        logic [39:0] pos;
        logic [7:0]  summary;
    } efc_safe_t;
    // parameter message kinds
    typedef enum logic [1:0] {
        EFC_MSG_SHORT = 2'h1,
        EFC_MSG_LONG  = 2'h2
    } efc_msg_kind_t;
    // one-hot message slot state
    typedef enum logic [1:0] {
        EFC_SLOT_IDLE = 2'h1,
        EFC_SLOT_BUSY = 2'h2
    } efc_slot_t;
endpackage

// File: rtl/efc_msg_slot.sv
`timescale 1ns/1ps
// ----------------------------------------
// one outstanding transaction slot
// ----------------------------------------
module efc_msg_slot (
    input  wire logic clk_sys_in,
    input  wire logic rst_in,
    input  wire logic ce_in,
    input  wire logic req_in,
    input  wire logic done_in,
    output logic      busy_out,
    output logic      issue_out
);
    efc_pkg::efc_slot_t state_q;  // slot state
    efc_pkg::efc_slot_t state_d;  // next state

    // ----------------------------------------
    // next state
    // ----------------------------------------
    // no timeout: a long reply may take arbitrarily long
    always_comb begin
        state_d   = state_q;
        issue_out = 1'b0;
        case (state_q)
            efc_pkg::EFC_SLOT_IDLE: begin
                if (ce_in && req_in) begin
                    issue_out = 1'b1;
                    state_d   = efc_pkg::EFC_SLOT_BUSY;
                end
            end
            efc_pkg::EFC_SLOT_BUSY: begin
                if (ce_in && done_in) begin
                    state_d = efc_pkg::EFC_SLOT_IDLE;
                end
            end
            default: state_d = efc_pkg::EFC_SLOT_IDLE;
        endcase
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            state_q <= efc_pkg::EFC_SLOT_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    assign busy_out = (state_q == efc_pkg::EFC_SLOT_BUSY);

    // an accepted request must hold the slot and refuse a repeat on the next edge
    a_slot_single: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        issue_out |=> busy_out && !issue_out)
        else $error("second request issued while busy");
endmodule // efc_msg_slot

// File: rtl/efc_channel_logic.sv
`timescale 1ns/1ps
`include "efc_defs.svh"
module efc_channel_logic #(
    parameter int POS_W    = `EFC_POS_W,
    parameter int SPD_W    = `EFC_SPD_W,
    parameter int DEV_W    = `EFC_DEV_W,
    parameter int FREE_CYC = `EFC_FREE_PKG_CYC
) (
    input  wire logic               clk_sys_in,
    input  wire logic               rst_in,
    input  wire logic               ce_in,
    // application side
    input  wire logic               sync_mode_in,      // 1 sync, 0 free running
    input  wire logic               cycle_sync_in,     // inverter cycle pulse
    input  wire logic [SPD_W-1:0]   max_speed_in,      // limits set by application
    input  wire logic [SPD_W-1:0]   max_accel_in,
    input  wire logic [DEV_W-1:0]   pos_tolerance_in,  // allowed safe/fast gap
    // link side, one pulse per package
    output logic                    pos_req_out,       // sample request to link
    input  wire logic               pkg_valid_in,
    input  wire logic               pkg_crc_ok_in,
    input  wire efc_pkg::efc_fast_t fast_in,
    input  wire logic               safe_valid_in,
    input  wire efc_pkg::efc_safe_t safe_in,
    input  wire logic [15:0]        sens_in,
    // parameter channel
    input  wire logic               short_req_in,
    input  wire logic               short_done_in,
    input  wire logic               long_req_in,
    input  wire logic               long_done_in,
    output logic                    short_busy_out,
    output logic                    short_issue_out,
    output logic                    long_busy_out,
    output logic                    long_issue_out,
    // results
    output efc_pkg::efc_fast_t      fast_out,
    output logic                    fast_valid_out,
    output logic                    pos_estimated_out,
    output logic [DEV_W-1:0]        pos_deviation_out,
    output logic                    pos_mismatch_out,
    output efc_pkg::efc_safe_t      safe_out,
    output logic                    sens_valid_out,
    output logic [15:0]             sens_out,
    output logic                    sens_err_out
);
    // ----------------------------------------
    // package request pacing
    // ----------------------------------------
    logic [15:0] free_cnt_q;  // free-running spacing counter
    logic [15:0] free_cnt_d;
    logic        req_now;     // request this cycle

    // sync mode follows the cycle pulse; free mode paces itself
    always_comb begin
        free_cnt_d = free_cnt_q;
        req_now    = 1'b0;
        if (sync_mode_in) begin
            req_now    = cycle_sync_in;
            free_cnt_d = 16'h0000;
        end else if (free_cnt_q == 16'(FREE_CYC - 1)) begin
            req_now    = 1'b1;
            free_cnt_d = 16'h0000;
        end else begin
            free_cnt_d = free_cnt_q + 16'h0001;
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            free_cnt_q <= 16'h0000;
        end else if (ce_in) begin
            free_cnt_q <= free_cnt_d;
        end
    end

    assign pos_req_out = ce_in && req_now;

    // ----------------------------------------
    // safe channel history
    // ----------------------------------------
    logic [POS_W-1:0] safe0_q;  // newest safe position
    logic [POS_W-1:0] safe1_q;  // previous safe position
    logic [1:0]       hist_q;   // number of safe samples seen, saturating at 2
    efc_pkg::efc_safe_t safe_q;
    logic [POS_W-1:0] safe0_d;
    logic [POS_W-1:0] safe1_d;
    logic [1:0]       hist_d;
    efc_pkg::efc_safe_t safe_d;

    // taken whenever it arrives, never tied to sync
    always_comb begin
        safe0_d = safe0_q;
        safe1_d = safe1_q;
        hist_d  = hist_q;
        safe_d  = safe_q;
        if (safe_valid_in) begin
            safe1_d = safe0_q;
            safe0_d = safe_in.pos;
            safe_d  = safe_in;
            if (hist_q != 2'h2) begin
                hist_d = hist_q + 2'h1;
            end
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            safe0_q <= `EFC_POS_RST;
            safe1_q <= `EFC_POS_RST;
            hist_q  <= 2'h0;
            safe_q  <= '0;
        end else if (ce_in) begin
            safe0_q <= safe0_d;
            safe1_q <= safe1_d;
            hist_q  <= hist_d;
            safe_q  <= safe_d;
        end
    end

    // second safe channel carries a copy; standard build drops it
    assign safe_out = safe_q;

    // ----------------------------------------
    // fast position, estimate and check
    // ----------------------------------------
    logic [POS_W-1:0] est_pos;    // linear extrapolation
    logic [POS_W-1:0] gap;        // |safe - fast|
    logic             mismatch;
    logic             use_est;
    efc_pkg::efc_fast_t fast_q;
    efc_pkg::efc_fast_t fast_d;
    logic             fvalid_q;
    logic             fvalid_d;
    logic             est_q;
    logic             est_d;
    logic             mis_q;
    logic             mis_d;
    logic [DEV_W-1:0] dev_q;
    logic [DEV_W-1:0] dev_d;

    // estimate error grows with the acceleration limit; speed limit adds margin
    always_comb begin
        est_pos  = safe0_q + (safe0_q - safe1_q);
        gap      = (safe0_q > fast_in.pos) ? safe0_q - fast_in.pos : fast_in.pos - safe0_q;
        mismatch = safe_valid_in && pkg_crc_ok_in && (hist_q != 2'h0)
                   && (gap > POS_W'(pos_tolerance_in));
        use_est  = !pkg_crc_ok_in || mismatch;
        fast_d   = fast_q;
        fvalid_d = 1'b0;
        est_d    = est_q;
        mis_d    = mis_q;
        dev_d    = dev_q;
        if (pkg_valid_in) begin
            fvalid_d = 1'b1;
            mis_d    = mismatch;
            est_d    = use_est;
            if (use_est) begin
                fast_d.pos = est_pos;
                fast_d.spd = max_speed_in;
                dev_d      = DEV_W'(max_accel_in) + DEV_W'(max_speed_in);
            end else begin
                fast_d = fast_in;
                dev_d  = `EFC_DEV_RST;
            end
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            fast_q   <= '0;
            fvalid_q <= 1'b0;
            est_q    <= 1'b0;
            mis_q    <= 1'b0;
            dev_q    <= `EFC_DEV_RST;
        end else if (ce_in) begin
            fast_q   <= fast_d;
            fvalid_q <= fvalid_d;
            est_q    <= est_d;
            mis_q    <= mis_d;
            dev_q    <= dev_d;
        end
    end

    assign fast_out          = fast_q;
    assign fast_valid_out    = fvalid_q;
    assign pos_estimated_out = est_q;
    assign pos_deviation_out = dev_q;
    assign pos_mismatch_out  = mis_q;

    // ----------------------------------------
    // sensor extension channel
    // ----------------------------------------
    logic [15:0] sens_q;
    logic [15:0] sens_d;
    logic        svalid_q;
    logic        svalid_d;
    logic        serr_q;
    logic        serr_d;

    // only transfer quality is judged, content passes untouched
    always_comb begin
        sens_d   = sens_q;
        svalid_d = pkg_valid_in;
        serr_d   = serr_q;
        if (pkg_valid_in) begin
            sens_d = sens_in;
            serr_d = !pkg_crc_ok_in;
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            sens_q   <= 16'h0000;
            svalid_q <= 1'b0;
            serr_q   <= 1'b0;
        end else if (ce_in) begin
            sens_q   <= sens_d;
            svalid_q <= svalid_d;
            serr_q   <= serr_d;
        end
    end

    assign sens_out       = sens_q;
    assign sens_valid_out = svalid_q;
    assign sens_err_out   = serr_q;

    // ----------------------------------------
    // parameter channel slots
    // ----------------------------------------
    efc_msg_slot u_short (
        .clk_sys_in (clk_sys_in),
        .rst_in     (rst_in),
        .ce_in      (ce_in),
        .req_in     (short_req_in),
        .done_in    (short_done_in),
        .busy_out   (short_busy_out),
        .issue_out  (short_issue_out)
    );
    efc_msg_slot u_long (
        .clk_sys_in (clk_sys_in),
        .rst_in     (rst_in),
        .ce_in      (ce_in),
        .req_in     (long_req_in),
        .done_in    (long_done_in),
        .busy_out   (long_busy_out),
        .issue_out  (long_issue_out)
    );

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence s_bad_pkg;
        ce_in && pkg_valid_in && !pkg_crc_ok_in;
    endsequence

    a_fast_refresh: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        ce_in && pkg_valid_in |=> fast_valid_out)
        else $error("package did not refresh fast data");
    a_sync_request: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        ce_in && sync_mode_in && cycle_sync_in |-> pos_req_out)
        else $error("sync pulse without position request");
    a_est_on_fault: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        s_bad_pkg |=> pos_estimated_out && fast_out.pos == $past(est_pos))
        else $error("fault did not substitute estimate");
    a_dev_reported: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !pos_estimated_out |-> pos_deviation_out == '0)
        else $error("deviation shown for measured position");
    a_mismatch_est: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        pos_mismatch_out |-> pos_estimated_out)
        else $error("mismatch without estimate");
    a_safe_capture: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        ce_in && safe_valid_in |=> safe_out == $past(safe_in))
        else $error("safe data not captured");
    a_sens_quality: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        s_bad_pkg |=> sens_err_out && sens_valid_out)
        else $error("sensor transfer fault not flagged");
    a_free_pacing: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        ce_in && !sync_mode_in && pos_req_out ##1 (ce_in && !sync_mode_in)
        |-> !pos_req_out)
        else $error("free running requests back to back");
endmodule // efc_channel_logic

// File: dv/efc_enc_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// encoder end of the link, behavioural
// ----------------------------------------
module efc_enc_model (
    input  wire logic          clk_sys_in,
    input  wire logic          short_issue_in,
    input  wire logic          long_issue_in,
    input  wire logic [15:0]   short_lat_in,
    input  wire logic [15:0]   long_lat_in,
    output logic               pkg_valid_out,
    output logic               crc_ok_out,
    output efc_pkg::efc_fast_t fast_out,
    output logic               safe_valid_out,
    output efc_pkg::efc_safe_t safe_out,
    output logic [15:0]        sens_out,
    output logic               short_done_out,
    output logic               long_done_out
);
    // quiet link at time zero
    initial begin
        pkg_valid_out = 1'b0;
        crc_ok_out = 1'b1;
        fast_out = 56'h0;
        safe_valid_out = 1'b0;
        safe_out = 48'h0;
        sens_out = 16'h0;
        short_done_out = 1'b0;
        long_done_out = 1'b0;
    end
    // one package; fast contents always sent whole
    task pkg(input logic [55:0] fast, input logic crc, input logic [15:0] sens,
             input logic sv, input logic [47:0] safe);
        @(negedge clk_sys_in);
        pkg_valid_out = 1'b1;
        crc_ok_out = crc;
        fast_out = fast;
        sens_out = sens;
        safe_valid_out = sv;
        safe_out = safe;
    endtask
    // safe channel update between packages, not tied to sync
    task safe(input logic [47:0] s);
        @(negedge clk_sys_in);
        pkg_valid_out = 1'b0;
        safe_valid_out = 1'b1;
        safe_out = s;
    endtask
    // released lines show inverted data so stale values cannot pass
    task idle;
        @(negedge clk_sys_in);
        pkg_valid_out = 1'b0;
        safe_valid_out = 1'b0;
        fast_out = ~fast_out;
        safe_out = ~safe_out;
        sens_out = ~sens_out;
    endtask
    // short messages served by interface logic, quick answer
    initial begin
        forever begin
            @(posedge clk_sys_in iff short_issue_in === 1'b1);
            repeat (short_lat_in) @(negedge clk_sys_in);
            short_done_out = 1'b1;
            @(negedge clk_sys_in);
            short_done_out = 1'b0;
        end
    end
    // long messages go through the processor, slow answer
    initial begin
        forever begin
            @(posedge clk_sys_in iff long_issue_in === 1'b1);
            repeat (long_lat_in) @(negedge clk_sys_in);
            long_done_out = 1'b1;
            @(negedge clk_sys_in);
            long_done_out = 1'b0;
        end
    end
endmodule // efc_enc_model

// File: dv/efc_channel_logic_tb.sv
`timescale 1ns/1ps
module efc_channel_logic_tb;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic               clk_sys_in, rst_in, sync_mode, cyc_sync, short_req, long_req, ce;
    logic [15:0]        max_spd, max_acc, short_lat, long_lat, sens_in, sens_out;
    logic [23:0]        tol, pos_dev;
    logic               pos_req, pkg_v, crc_ok, safe_v, short_done, long_done;
    logic               short_busy, short_iss, long_busy, long_iss, fast_v;
    logic               pos_est, pos_mis, sens_v, sens_err;
    efc_pkg::efc_fast_t fast_in, fast_out;
    efc_pkg::efc_safe_t safe_in, safe_out;
    int                 num_errors = 0;
    int                 n_checks = 0;
    // ----------------------------------------
    // design and encoder model
    // ----------------------------------------
    efc_channel_logic #(.FREE_CYC(8)) efc_channel_logic_inst (
        .clk_sys_in(clk_sys_in), .rst_in(rst_in), .ce_in(ce),
        .sync_mode_in(sync_mode), .cycle_sync_in(cyc_sync), .max_speed_in(max_spd),
        .max_accel_in(max_acc), .pos_tolerance_in(tol), .pos_req_out(pos_req),
        .pkg_valid_in(pkg_v), .pkg_crc_ok_in(crc_ok), .fast_in(fast_in),
        .safe_valid_in(safe_v), .safe_in(safe_in), .sens_in(sens_in),
        .short_req_in(short_req), .short_done_in(short_done), .long_req_in(long_req),
        .long_done_in(long_done), .short_busy_out(short_busy), .short_issue_out(short_iss),
        .long_busy_out(long_busy), .long_issue_out(long_iss), .fast_out(fast_out),
        .fast_valid_out(fast_v), .pos_estimated_out(pos_est), .pos_deviation_out(pos_dev),
        .pos_mismatch_out(pos_mis), .safe_out(safe_out), .sens_valid_out(sens_v),
        .sens_out(sens_out), .sens_err_out(sens_err));
    efc_enc_model enc (
        .clk_sys_in(clk_sys_in), .short_issue_in(short_iss), .long_issue_in(long_iss),
        .short_lat_in(short_lat), .long_lat_in(long_lat), .pkg_valid_out(pkg_v),
        .crc_ok_out(crc_ok), .fast_out(fast_in), .safe_valid_out(safe_v),
        .safe_out(safe_in), .sens_out(sens_in), .short_done_out(short_done),
        .long_done_out(long_done));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task wrap_up;
        if (num_errors == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    // back-to-back packages, each refreshes fast data and sensor data
    // the second one stands for an extra package inside the same inverter cycle
    task t_pkg;
        enc.pkg({40'h00_1234_5678, 16'h0042}, 1'b1, 16'hbeef, 1'b0, 48'h0);
        enc.pkg({40'h00_0000_0111, 16'h0007}, 1'b1, 16'h0101, 1'b0, 48'h0);
        chk(fast_out, {40'h00_1234_5678, 16'h0042});
        chk({fast_v, sens_v, sens_out}, {2'b11, 16'hbeef});
        enc.idle;
        chk(fast_out, {40'h00_0000_0111, 16'h0007});
        chk({pos_est, sens_err, sens_out}, {2'b00, 16'h0101});
        enc.idle;
        chk({fast_v, sens_v}, 2'b00);
    endtask
    // two safe updates build the history used by the estimate
    task t_safe;
        enc.safe({40'h00_0000_0064, 8'h81});
        enc.idle;
        chk(safe_out, {40'h00_0000_0064, 8'h81});
        enc.safe({40'h00_0000_006e, 8'h04});
        enc.idle;
        chk(safe_out, {40'h00_0000_006e, 8'h04});
    endtask
    // bad package, then safe/fast mismatch, then a close match
    task t_est;
        enc.pkg({40'h00_0000_0abc, 16'h0001}, 1'b0, 16'h0002, 1'b0, 48'h0);
        enc.idle;
        chk(fast_out, {40'h00_0000_0078, 16'h0100});
        chk(pos_dev, 24'h000120);
        chk({pos_est, sens_err}, 2'b11);
        enc.pkg({40'h00_0000_01f4, 16'h0001}, 1'b1, 16'h0002, 1'b1, {40'h6e, 8'h0});
        enc.idle;
        chk({pos_mis, pos_est, fast_out.pos}, {2'b11, 40'h00_0000_0078});
        enc.pkg({40'h00_0000_0070, 16'h0009}, 1'b1, 16'h0003, 1'b1, {40'h6e, 8'h0});
        enc.idle;
        chk({pos_mis, pos_est, fast_out.pos}, {2'b00, 40'h00_0000_0070});
    endtask
    // clock enable low: a faulty package, a sync pulse and a request all ignored
    task t_hold;
        @(negedge clk_sys_in);
        ce = 1'b0;
        short_req = 1'b1;
        cyc_sync = 1'b1;
        enc.pkg({40'h00_0000_0999, 16'h0005}, 1'b0, 16'h0777, 1'b1, {40'h99, 8'h5a});
        enc.idle;
        chk({fast_v, pos_est, sens_err}, 3'h0);
        chk({short_iss, pos_req}, 2'b00);
        chk(fast_out, {40'h00_0000_0070, 16'h0009});
        chk(sens_out, 16'h0003);
        chk(safe_out, {40'h00_0000_006e, 8'h00});
        short_req = 1'b0;
        cyc_sync = 1'b0;
        ce = 1'b1;
    endtask
    // sync mode follows the cycle pulse, free mode paces itself
    task t_req;
        int n;
        n = 0;
        @(negedge clk_sys_in);
        cyc_sync = 1'b1;
        #1 chk(pos_req, 1'b1);
        @(negedge clk_sys_in);
        cyc_sync = 1'b0;
        sync_mode = 1'b0;
        #1 chk(pos_req, 1'b0);
        repeat (8) @(negedge clk_sys_in);
        repeat (32) begin
            @(negedge clk_sys_in);
            if (pos_req === 1'b1) n++;
        end
        chk(64'(n), 64'h4);
        sync_mode = 1'b1;
    endtask
    // one short and one long at a time, repeats refused while busy
    task t_slot;
        int n;
        n = 0;
        @(negedge clk_sys_in);
        short_req = 1'b1;
        long_req = 1'b1;
        #1 chk({short_iss, long_iss}, 2'b11);
        @(negedge clk_sys_in);
        chk({short_busy, long_busy, short_iss, long_iss}, 4'b1100);
        short_req = 1'b0;
        long_req = 1'b0;
        while (short_busy === 1'b1 && n < 50) begin
            @(negedge clk_sys_in);
            n++;
        end
        chk({short_busy, long_busy}, 2'b01);
        n = 0;
        while (long_busy === 1'b1 && n < 1000) begin
            @(negedge clk_sys_in);
            n++;
        end
        chk(long_busy, 1'b0);
        if (n == 1000) wrap_up;
    endtask
    // ----------------------------------------
    // clock, watchdog and main sequence
    // ----------------------------------------
    initial begin
        clk_sys_in = 1'b0;
        forever #2 clk_sys_in = ~clk_sys_in;
    end
    initial begin
        #40000;
        num_errors++;
        wrap_up;
    end
    initial begin
        {sync_mode, cyc_sync, short_req, long_req, rst_in} = 5'h11;
        ce = 1'b1;
        max_spd = 16'h0100; // speed and accel limits set by the application
        max_acc = 16'h0020;
        tol = 24'h000005;
        short_lat = 16'h0003;
        long_lat = 16'h012c;
        repeat (16) @(negedge clk_sys_in);
        rst_in = 1'b0;
        chk({fast_v, short_busy, long_busy, pos_est}, 4'h0);
        t_pkg;
        t_safe;
        t_est;
        t_hold;
        t_req;
        t_slot;
        wrap_up;
    end
endmodule // efc_channel_logic_tb
